/* design/ext_zone_pkg.sv */
// constants, types and helpers of the external zone access sequencer
// assumes one system clock that also serves as the interface timing clock
package ext_zone_pkg;
  localparam int ZONES = 4;
  localparam int ZW = 2;
  localparam int TIMING_W = 17;
  localparam int ADDR_W = 8;
  localparam int PIN_ADDR_W = 16;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] ZONE_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ZONE_STRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAITS_LSB = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [7:0] WAIT_ONE = 8'h01;
  localparam logic [7:0] WAIT_MAX = 8'hff;
  localparam logic [3:0] ZONE_ONE = 4'h1;
  localparam logic [3:0] ZONE_NONE = 4'hf;

  // one zone timing word, doubler in the top bit
  typedef struct packed {
    logic       dbl;
    logic       syncSel;
    logic       hsEn;
    logic [1:0] rdLead;
    logic [2:0] rdActive;
    logic [1:0] rdTrail;
    logic [1:0] wrLead;
    logic [2:0] wrActive;
    logic [1:0] wrTrail;
  } timing_t;
  localparam timing_t TIMING_RESET = 17'h03fff;

  typedef enum logic [3:0] {
    PH_IDLE   = 4'b0001,
    PH_LEAD   = 4'b0010,
    PH_ACTIVE = 4'b0100,
    PH_TRAIL  = 4'b1000
  } phase_t;

  typedef struct packed {
    logic                  req;
    logic                  write;
    logic [ZW-1:0]         zone;
    logic [PIN_ADDR_W-1:0] addr;
  } acc_req_t;

  typedef struct packed {
    logic [ZONES-1:0]      zoneSelN;
    logic                  readN;
    logic                  writeN;
    logic [PIN_ADDR_W-1:0] addr;
  } ext_pins_t;

  function automatic logic [3:0] scale(input logic [2:0] n, input logic dbl);
    return dbl ? {n, 1'b0} : {1'b0, n};
  endfunction

  function automatic logic [3:0] leadLen(input timing_t t, input logic wr);
    return scale(wr ? {1'b0, t.wrLead} : {1'b0, t.rdLead}, t.dbl);
  endfunction

  function automatic logic [3:0] activeBase(input timing_t t, input logic wr);
    return scale(wr ? t.wrActive : t.rdActive, t.dbl) + CNT_ONE;
  endfunction

  function automatic logic [3:0] trailLen(input timing_t t, input logic wr);
    return scale(wr ? {1'b0, t.wrTrail} : {1'b0, t.rdTrail}, t.dbl);
  endfunction
endpackage

/* design/external_zone_access_timing.sv */
// lead / active / trail sequencer for external zone accesses
// assumes clk_sys is the interface timing clock and requests come from clk_sys logic
`timescale 1ns/1ps
`default_nettype none
module external_zone_access_timing
  import ext_zone_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // AHB-Lite register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // host access request
  input  wire acc_req_t    accIn,
  output logic             accIdle,
  output logic             accDone,
  // external bus pins
  output ext_pins_t        extPins,
  input  wire logic        extReady
);
  typedef struct packed {
    phase_t    phase;
    logic [3:0] cnt;
    logic [7:0] waits;
    timing_t   cfg;
    logic      isWrite;
    logic [ZW-1:0] zone;
    ext_pins_t pins;
    logic      idle;
    logic      done;
    logic [7:0] lastWaits;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    phase: PH_IDLE,
    cfg: TIMING_RESET,
    pins: '{zoneSelN: ZONE_NONE, readN: 1'b1, writeN: 1'b1, addr: '0},
    idle: 1'b1,
    default: '0
  };

  top_state_t s;
  top_state_t next_s;

  timing_t [ZONES-1:0] zoneCfg;
  timing_t selCfg;
  logic readyUsed;
  logic hold;

  zone_timing_regs u_regs (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .busy      (!s.idle),
    .lastWaits (s.lastWaits),
    .zoneCfg   (zoneCfg)
  );

  // mode comes from the latched word so a mid-access write cannot change it
  ready_sampler u_ready (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .readyPin  (extReady),
    .asyncSel  (s.cfg.syncSel),
    .readyUsed (readyUsed)
  );

  assign selCfg = zoneCfg[accIn.zone];

  // stretch only at the last base cycle of active
  assign hold = s.cfg.hsEn && !readyUsed;

  function automatic logic [ZONES-1:0] zoneBit(input logic [ZW-1:0] z);
    return ZONES'(ZONE_ONE << z);
  endfunction

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.phase)
      PH_IDLE: begin
        if (accIn.req) begin
          next_s.cfg = selCfg;
          next_s.isWrite = accIn.write;
          next_s.zone = accIn.zone;
          next_s.waits = '0;
          next_s.pins.addr = accIn.addr;
          // a zero lead is not trapped, active starts at once
          if (leadLen(selCfg, accIn.write) != CNT_ZERO) begin
            next_s.phase = PH_LEAD;
            next_s.cnt = leadLen(selCfg, accIn.write);
          end else begin
            next_s.phase = PH_ACTIVE;
            next_s.cnt = activeBase(selCfg, accIn.write);
          end
        end
      end
      PH_LEAD: begin
        if (s.cnt == CNT_ONE) begin
          next_s.phase = PH_ACTIVE;
          next_s.cnt = activeBase(s.cfg, s.isWrite);
        end else begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
      end
      PH_ACTIVE: begin
        if (s.cnt != CNT_ONE) begin
          next_s.cnt = s.cnt - CNT_ONE;
        end else if (hold) begin
          // counter saturates; the hold itself goes on regardless
          if (s.waits != WAIT_MAX) next_s.waits = s.waits + WAIT_ONE;
        end else if (trailLen(s.cfg, s.isWrite) != CNT_ZERO) begin
          next_s.phase = PH_TRAIL;
          next_s.cnt = trailLen(s.cfg, s.isWrite);
        end else begin
          next_s.phase = PH_IDLE;
          next_s.done = 1'b1;
          next_s.lastWaits = s.waits;
        end
      end
      PH_TRAIL: begin
        if (s.cnt == CNT_ONE) begin
          next_s.phase = PH_IDLE;
          next_s.done = 1'b1;
          next_s.lastWaits = s.waits;
        end else begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
    // pins follow the phase flops of the same edge
    next_s.pins.zoneSelN = (next_s.phase != PH_IDLE) ? ~zoneBit(next_s.zone) : ZONE_NONE;
    next_s.pins.readN = !(next_s.phase == PH_ACTIVE && !next_s.isWrite);
    next_s.pins.writeN = !(next_s.phase == PH_ACTIVE && next_s.isWrite);
    next_s.idle = (next_s.phase == PH_IDLE);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign accIdle = s.idle;
  assign accDone = s.done;
  assign extPins = s.pins;

  // cycles spent in the current phase, read only by the checks below
  logic [8:0] cyc;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cyc <= '0;
    end else if (next_s.phase != s.phase) begin
      cyc <= 9'h001;
    end else begin
      cyc <= cyc + 9'h001;
    end
  end

  logic leadExit;
  logic activeExit;
  logic trailExit;
  assign leadExit = (s.phase == PH_LEAD) && (next_s.phase != PH_LEAD);
  assign activeExit = (s.phase == PH_ACTIVE) && (next_s.phase != PH_ACTIVE);
  assign trailExit = (s.phase == PH_TRAIL) && (next_s.phase != PH_TRAIL);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  phase_order_a: assert property (
    (leadExit |-> next_s.phase == PH_ACTIVE) and
    ($rose(s.phase == PH_TRAIL) |-> $past(s.phase) == PH_ACTIVE))
    else $error("phases out of order");

  zone_cfg_a: assert property (
    (s.phase == PH_IDLE && accIn.req) |=> (s.cfg == $past(selCfg) && s.zone == $past(accIn.zone)))
    else $error("access not timed by its own zone word");

  zone_pin_a: assert property (
    (s.phase != PH_IDLE) |-> s.pins.zoneSelN == ~zoneBit(s.zone))
    else $error("wrong zone select driven");

  lead_len_a: assert property (
    leadExit |-> cyc == {5'h00, leadLen(s.cfg, s.isWrite)})
    else $error("lead phase length wrong");

  active_len_a: assert property (
    activeExit |-> cyc == {5'h00, activeBase(s.cfg, s.isWrite)} + {1'b0, s.waits})
    else $error("active phase length wrong");

  trail_len_a: assert property (
    trailExit |-> cyc == {5'h00, trailLen(s.cfg, s.isWrite)})
    else $error("trail phase length wrong");

  no_wait_a: assert property (
    (s.phase == PH_ACTIVE && !s.cfg.hsEn) |-> (s.waits == '0 && cyc <= {5'h00, activeBase(s.cfg, s.isWrite)}))
    else $error("wait state without handshake sampling");

  hold_a: assert property (
    (s.phase == PH_ACTIVE && s.cnt == CNT_ONE && hold && s.waits != WAIT_MAX)
      |=> (s.phase == PH_ACTIVE && s.waits == $past(s.waits) + WAIT_ONE))
    else $error("not-ready did not hold active");

  strobe_a: assert property (
    (s.pins.readN == !(s.phase == PH_ACTIVE && !s.isWrite)) &&
    (s.pins.writeN == !(s.phase == PH_ACTIVE && s.isWrite)))
    else $error("strobe off its phase");

  done_a: assert property (
    $rose(s.phase == PH_IDLE) |-> (accDone && accIdle) ##1 !accDone)
    else $error("done pulse wrong");

  // cycles since the access was taken, read only by the checks below
  logic [9:0] accCyc;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      accCyc <= '0;
    end else if (s.phase == PH_IDLE) begin
      accCyc <= '0;
    end else begin
      accCyc <= accCyc + 10'h001;
    end
  end

  total_len_a: assert property (
    accDone |-> accCyc == {6'h00, leadLen(s.cfg, s.isWrite)} + {6'h00, activeBase(s.cfg, s.isWrite)}
      + {6'h00, trailLen(s.cfg, s.isWrite)} + {2'h0, s.waits})
    else $error("access length not lead plus active plus trail");

  lead_quiet_a: assert property (
    (s.phase == PH_LEAD) |-> (s.pins.readN && s.pins.writeN && s.pins.zoneSelN != ZONE_NONE))
    else $error("strobe or select wrong in lead");

  trail_quiet_a: assert property (
    (s.phase == PH_TRAIL) |-> (s.pins.readN && s.pins.writeN && s.pins.zoneSelN != ZONE_NONE))
    else $error("strobe or select wrong in trail");

  idle_pins_a: assert property (
    (s.phase == PH_IDLE) |-> (s.pins.zoneSelN == ZONE_NONE && s.pins.readN && s.pins.writeN))
    else $error("pins driven while idle");

  one_strobe_a: assert property (
    s.pins.readN || s.pins.writeN)
    else $error("read and write strobes low together");

  read_strobe_a: assert property (
    (s.phase == PH_ACTIVE && !s.isWrite) |-> (!s.pins.readN && s.pins.writeN))
    else $error("read active without read strobe");

  write_strobe_a: assert property (
    (s.phase == PH_ACTIVE && s.isWrite) |-> (!s.pins.writeN && s.pins.readN))
    else $error("write active without write strobe");

  addr_stable_a: assert property (
    (s.phase != PH_IDLE && $past(s.phase) != PH_IDLE) |-> $stable(s.pins.addr))
    else $error("address moved inside an access");

  cfg_stable_a: assert property (
    (s.phase != PH_IDLE && $past(s.phase) != PH_IDLE) |-> $stable(s.cfg))
    else $error("timing word changed inside an access");

  busy_refuse_a: assert property (
    (s.phase != PH_IDLE) |=> $stable(s.zone))
    else $error("zone changed while busy");

  zero_lead_a: assert property (
    (s.phase == PH_IDLE && accIn.req && leadLen(selCfg, accIn.write) == CNT_ZERO) |=> s.phase == PH_ACTIVE)
    else $error("zero lead did not go straight to active");

  zero_trail_a: assert property (
    (activeExit && trailLen(s.cfg, s.isWrite) == CNT_ZERO) |=> accDone)
    else $error("zero trail did not end the access");

  wait_clear_a: assert property (
    (s.phase == PH_IDLE && accIn.req) |=> s.waits == '0)
    else $error("wait count not cleared at start");

  last_waits_a: assert property (
    accDone |-> s.lastWaits == s.waits)
    else $error("reported wait count wrong");

  sync_hold_a: assert property (
    (s.phase == PH_ACTIVE && s.cnt == CNT_ONE && s.cfg.hsEn && !s.cfg.syncSel && !$past(extReady, 2))
      |=> s.phase == PH_ACTIVE)
    else $error("sync not-ready did not hold");

  async_hold_a: assert property (
    (s.phase == PH_ACTIVE && s.cnt == CNT_ONE && s.cfg.hsEn && s.cfg.syncSel && !$past(extReady, 3))
      |=> s.phase == PH_ACTIVE)
    else $error("async not-ready did not hold");

  sync_pass_a: assert property (
    (s.phase == PH_ACTIVE && s.cnt == CNT_ONE && s.cfg.hsEn && !s.cfg.syncSel && $past(extReady, 2))
      |=> s.phase != PH_ACTIVE)
    else $error("sync ready did not end active");

  async_pass_a: assert property (
    (s.phase == PH_ACTIVE && s.cnt == CNT_ONE && s.cfg.hsEn && s.cfg.syncSel && $past(extReady, 3))
      |=> s.phase != PH_ACTIVE)
    else $error("async ready did not end active");

  async_wait_cv: cover property (
    activeExit && s.cfg.syncSel && s.waits != '0);
  wait_cv: cover property (
    s.phase == PH_ACTIVE && hold ##1 s.phase == PH_ACTIVE ##1 s.phase == PH_TRAIL);
  dbl_read_cv: cover property (
    trailExit && s.cfg.dbl && !s.isWrite);
  write_no_trail_cv: cover property (
    activeExit && s.isWrite && next_s.phase == PH_IDLE);
  zero_lead_cv: cover property (
    s.phase == PH_IDLE && accIn.req ##1 s.phase == PH_ACTIVE);
endmodule
`default_nettype wire

/* design/ready_sampler.sv */
// synchroniser and mode select for the external handshake input
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module ready_sampler
  import ext_zone_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // handshake
  input  wire logic readyPin,
  input  wire logic asyncSel,
  output logic      readyUsed
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic late;
  } sampler_state_t;

  sampler_state_t s;
  sampler_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = readyPin;
    next_s.s2 = s.s1;
    next_s.late = s.s2;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // async mode trades one cycle of latency for settling margin
  assign readyUsed = asyncSel ? s.late : s.s2;

  sync_mode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!asyncSel && $past(resetn, 3)) |-> readyUsed == $past(readyPin, 2))
    else $error("sync handshake sample not two cycles late");
  async_mode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (asyncSel && $past(resetn, 4)) |-> readyUsed == $past(readyPin, 3))
    else $error("async handshake sample not three cycles late");
endmodule
`default_nettype wire

/* design/zone_timing_regs.sv */
// AHB-Lite slave holding the per-zone timing words and a status word
// assumes a single master and word transfers only
`timescale 1ns/1ps
`default_nettype none
module zone_timing_regs
  import ext_zone_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  // AHB-Lite
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  // sequencer side
  input  wire logic                   busy,
  input  wire logic [7:0]             lastWaits,
  output timing_t [ZONES-1:0]         zoneCfg
);
  typedef struct packed {
    timing_t [ZONES-1:0] cfg;
    logic                wrPend;
    logic [ADDR_W-1:0]   wrAddr;
    logic [31:0]         rdata;
    logic                readyOut;
  } regs_state_t;

  regs_state_t s;
  regs_state_t next_s;

  function automatic logic [ADDR_W-1:0] zoneOfs(input int i);
    return ADDR_W'(ZONE_BASE + ZONE_STRIDE * i);
  endfunction

  function automatic logic [31:0] readWord(input logic [ADDR_W-1:0] a,
                                           input timing_t [ZONES-1:0] c,
                                           input logic b,
                                           input logic [7:0] w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < ZONES; i++) begin
      if (a == zoneOfs(i)) r[TIMING_W-1:0] = c[i];
    end
    if (a == STATUS_OFS) begin
      r[STAT_BUSY_BIT] = b;
      r[STAT_WAITS_LSB +: 8] = w;
    end
    return r;
  endfunction

  always_comb begin
    next_s = s;
    next_s.readyOut = 1'b1;
    if (s.wrPend) begin
      for (int i = 0; i < ZONES; i++) begin
        if (s.wrAddr == zoneOfs(i)) next_s.cfg[i] = hwdata[TIMING_W-1:0];
      end
    end
    next_s.wrPend = 1'b0;
    if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
      next_s.wrPend = hwrite;
      next_s.wrAddr = haddr[ADDR_W-1:0];
      // read sees a write still in its data phase
      if (!hwrite) next_s.rdata = readWord(haddr[ADDR_W-1:0], next_s.cfg, busy, lastWaits);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{cfg: {ZONES{TIMING_RESET}}, readyOut: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.readyOut;
  assign hrdata = s.rdata;
  assign hresp = 1'b0;
  assign zoneCfg = s.cfg;
endmodule
`default_nettype wire

/* verification/ext_device_model.sv */
// partner model: external part on a zone that answers the handshake
// assumes extPins come from the sequencer and share clk_sys
`timescale 1ns/1ps
`default_nettype none
module ext_device_model
  import ext_zone_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // bus side
  input  wire ext_pins_t  extPins,
  input  wire logic [3:0] stall,
  output logic            extReady
);
  logic [3:0] selCnt;
  logic       flip;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selCnt <= 4'h0;
      flip   <= 1'b0;
    end else begin
      flip <= ~flip;
      if (&extPins.zoneSelN)
        selCnt <= 4'h0;
      else if (selCnt != 4'hf)
        selCnt <= selCnt + 4'h1;
    end
  end

  // slow part: not ready for stall cycles after select
  // deselected the pin is not driven, so toggle instead of holding a level
  assign extReady = (&extPins.zoneSelN) ? flip : (selCnt >= stall);
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the external zone access sequencer
// assumes package, design files and partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ext_zone_pkg::*;
  logic        clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
  logic        accIdle, accDone, extReady, badStrobe;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  stall, selSeen;
  acc_req_t    accIn;
  ext_pins_t   extPins;
  int          failures, checks_done, leadCnt, actCnt, trailCnt;
  // zone timing table: dbl, rdLead, rdActive, rdTrail, wrLead, wrActive, wrTrail
  int cf[4][7] = '{'{0,1,1,1,2,3,0}, '{1,2,3,3,1,0,2}, '{0,0,0,0,0,7,3}, '{1,3,7,2,3,5,1}};

  external_zone_access_timing i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .accIn(accIn),
    .accIdle(accIdle), .accDone(accDone), .extPins(extPins), .extReady(extReady));

  ext_device_model i_dev (
    .clk_sys(clk_sys), .resetn(resetn), .extPins(extPins), .stall(stall), .extReady(extReady));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // phase counter, sampled mid-cycle where the pins are settled
  always @(negedge clk_sys) begin
    if (~&extPins.zoneSelN) begin
      selSeen |= ~extPins.zoneSelN;
      if (!extPins.readN || !extPins.writeN)
        actCnt++;
      else if (actCnt == 0)
        leadCnt++;
      else
        trailCnt++;
      if (!(accIn.write ? extPins.readN : extPins.writeN))
        badStrobe = 1'b1;
      if (extPins.addr !== accIn.addr)
        badStrobe = 1'b1;
    end
  end

  // strobes may only move with a rising edge
  always @(extPins.zoneSelN or extPins.readN or extPins.writeN) begin
    if (resetn === 1'b1 && clk_sys !== 1'b1) begin
      failures++;
      $display("[FAIL] t=%0t strobe moved off edge %h %h", $time, extPins, clk_sys);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] cw(input int z);
    return {15'h0, cf[z][0][0], 2'h0, cf[z][1][1:0], cf[z][2][2:0], cf[z][3][1:0],
            cf[z][4][1:0], cf[z][5][2:0], cf[z][6][1:0]};
  endfunction

  // single word transfer, entered just after a rising edge; ready and data taken at rising edges
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    hsize  <= 3'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic acc(input logic wr, input logic [1:0] z);
    int n;
    leadCnt = 0;
    actCnt = 0;
    trailCnt = 0;
    badStrobe = 1'b0;
    selSeen = 4'h0;
    n = 0;
    accIn <= '{1'b1, wr, z, 16'h00a5};
    do @(negedge clk_sys); while (accIdle !== 1'b1);
    @(posedge clk_sys);
    accIn.req <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (accDone !== 1'b1 && n < 200);
    check(n < 200, 1'b1);
    @(posedge clk_sys);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    check({extPins, accIdle, accDone}, {4'hf, 2'h3, 16'h0, 2'h2});
    ahb(1'b0, 8'h0c, 32'h0, rd);
    check(rd, 32'h3fff);
    check(hresp, 1'b0);
    ahb(1'b1, 8'h14, 32'hffffffff, rd);
    ahb(1'b0, 8'h14, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b0, STATUS_OFS, 32'h0, rd);
    check(rd, 32'h0);
    $display("reset test done");
  endtask

  // every zone differs; slow part but handshake ignored, zone 2 has zero lead
  task automatic t_phases();
    logic [31:0] rd;
    int m;
    stall <= 4'h5;
    for (int z = 0; z < 4; z++)
      ahb(1'b1, 8'(4 * z), cw(z), rd);
    for (int z = 0; z < 4; z++) begin
      ahb(1'b0, 8'(4 * z), 32'h0, rd);
      check(rd, cw(z));
      for (int wr = 0; wr < 2; wr++) begin
        m = cf[z][0] + 1;
        acc(wr[0], z[1:0]);
        check(leadCnt, cf[z][1 + 3 * wr] * m);
        check(actCnt, cf[z][2 + 3 * wr] * m + 1);
        check(trailCnt, cf[z][3 + 3 * wr] * m);
        check({selSeen, badStrobe}, {4'h1 << z, 1'b0});
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check(rd[8:1], 8'h0);
      end
    end
    $display("phase test done");
  endtask

  // lead 2, active 2, trail 1 suits both sampling modes
  // slow part ready from selected cycle stall+1, seen 2 (sync) or 3 (async) cycles later,
  // while the hold test starts at cycle lead+base = 5: waits 6+1+2-5 or 6+1+3-5
  task automatic t_waits();
    logic [31:0] rd;
    logic [7:0]  w;
    for (int m = 0; m < 4; m++) begin
      w = m[0] ? (m[1] ? 8'h05 : 8'h04) : 8'h00;
      stall <= m[0] ? 4'h6 : 4'h0;
      ahb(1'b1, 8'h00, {15'h0, 1'b0, m[1], 1'b1, 2'h2, 3'h2, 2'h1, 2'h2, 3'h2, 2'h1}, rd);
      acc(1'b0, 2'h0);
      ahb(1'b0, STATUS_OFS, 32'h0, rd);
      check(actCnt, 3 + w);
      check(rd[8:1], w);
    end
    $display("wait state test done");
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stall = 4'h0;
    accIn = '0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_phases();
    t_waits();
    finish_test();
  end

  // far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
